/* File: lsi2c_asserts.sv */
// assertion checker on the two-wire link and the target end's user side
`timescale 1ns/1ps
`default_nettype none
module lsi2c_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic int_req,
  input wire logic latched_mode,
  input wire logic int_act,
  input wire logic hs_mode,
  input wire logic gc_reset,
  input wire logic reg_wr,
  input wire logic [7:0] reg_ptr
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================
  // wire timing
  a_sda_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target changed sda while scl high");
  a_hs_code_nacked: assert property ($rose(hs_mode) |-> !dev_sda_oe)
    else $error("target pulled sda on entering high speed");
  a_stop_ends_hs: assert property (scl && $rose(sda) |-> ##[1:4] !hs_mode)
    else $error("high speed kept after stop");
  // ==========================================
  // user side pulses
  a_gc_clears_ptr: assert property (gc_reset |-> ##[0:1] reg_ptr == 8'h00)
    else $error("pointer not cleared by general call");
  a_gc_one_pulse: assert property (gc_reset |=> !gc_reset)
    else $error("general call pulse too long");
  a_wr_one_pulse: assert property (reg_wr |=> !reg_wr)
    else $error("write pulse too long");
  // ==========================================
  // interrupt pin
  a_int_follows_req: assert property ($rose(int_req) |=> int_act)
    else $error("interrupt not raised after request");
  a_int_release_latched: assert property ($fell(int_act) && $past(int_req) |-> latched_mode)
    else $error("interrupt released outside latched mode");
  c_gc: cover property (gc_reset);
  c_wr: cover property (reg_wr);
  c_alert_won: cover property ($fell(int_act) && int_req);
  c_hs_exit: cover property ($fell(hs_mode));
endmodule
`default_nettype wire

/* File: lsi2c_bench.sv */
// self-checking bench: ahb-lite driven controller against the target end
`timescale 1ns/1ps
`default_nettype none
module lsi2c_bench;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [1:0] addr_sel = 2'h2;
  logic burst_en = 1'h0;
  logic latched_mode = 1'h0;
  logic int_req = 1'h0;
  logic flag_h = 1'h0;
  logic hs = 1'h0;
  logic [7:0] reg_ptr;
  logic reg_wr;
  logic gc_reset;
  logic int_act;
  logic hs_mode;
  logic [15:0] reg_wdata;
  logic [15:0] last_wdata = 16'h0;
  logic [31:0] st;
  int gc_cnt = 0;
  int miscompares = 0;
  int checked = 0;
  // register stand-in: content follows the pointer
  wire logic [15:0] reg_rdata = {reg_ptr, reg_ptr ^ 8'hA5};
  lsi2c_if bus ();
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (reg_wr) last_wdata <= reg_wdata;
    if (gc_reset) gc_cnt <= gc_cnt + 1;
  end
  lsi2c_ctl #(.FS_QTR(8), .HS_QTR(6)) u_lsi2c_ctl (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .bus(bus.ctl));
  lsi2c_target #(.TIMEOUT_CYC(200)) u_lsi2c_target (.hclk(hclk), .hresetn(hresetn),
    .bus(bus.dev), .addr_sel(addr_sel), .reg_rdata(reg_rdata), .burst_en(burst_en),
    .latched_mode(latched_mode), .int_req(int_req), .flag_h(flag_h), .reg_ptr(reg_ptr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .gc_reset(gc_reset), .int_act(int_act),
    .hs_mode(hs_mode));
  lsi2c_asserts u_lsi2c_asserts (.hclk(hclk), .hresetn(hresetn), .scl(bus.scl),
    .sda(bus.sda), .dev_sda_oe(bus.dev_sda_oe), .int_req(int_req),
    .latched_mode(latched_mode), .int_act(int_act), .hs_mode(hs_mode),
    .gc_reset(gc_reset), .reg_wr(reg_wr), .reg_ptr(reg_ptr));
  // ==========================================
  // checking and closing
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================
  // ahb-lite single word transfer
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 100);
    if (!wr) st = hrdata;
    if (n >= 100) begin
      miscompares++;
      results();
    end
  endtask
  // ==========================================
  // byte level commands through the controller
  task automatic idle();
    int n;
    n = 0;
    do begin
      ahb(1'h0, 32'h4, 32'h0);
      n++;
    end while (st[0] !== 1'h0 && n < 400);
    if (n >= 400) begin
      miscompares++;
      results();
    end
  endtask
  task automatic op(input logic [1:0] cmd, input logic [7:0] b, input logic nk);
    idle();
    ahb(1'h1, 32'h0, {16'h0, b, 4'h0, nk, hs, cmd});
    idle();
  endtask
  task automatic start_c();
    op(2'h0, 8'h0, 1'h0);
  endtask
  task automatic stop_c();
    op(2'h1, 8'h0, 1'h0);
  endtask
  task automatic wb(input logic [7:0] b, input logic nack);
    op(2'h2, b, 1'h0);
    chk("ack bit", st[1], nack);
  endtask
  task automatic rb(input logic nk, input logic [7:0] exp);
    op(2'h3, 8'h0, nk);
    chk("read byte", st[15:8], exp);
  endtask
  // ==========================================
  // scenarios
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    // pointer write then two data bytes
    start_c();
    wb(8'h8C, 1'h0);
    wb(8'h12, 1'h0);
    wb(8'hAB, 1'h0);
    wb(8'hCD, 1'h0);
    stop_c();
    chk("pointer", reg_ptr, 8'h12);
    chk("write data", last_wdata, 16'hABCD);
    // plain read in a new transaction
    start_c();
    wb(8'h8D, 1'h0);
    rb(1'h0, 8'h12);
    rb(1'h1, 8'hB7);
    stop_c();
    // burst read, pointer restored on stop
    burst_en <= 1'h1;
    start_c();
    wb(8'h8D, 1'h0);
    rb(1'h0, 8'h12);
    rb(1'h0, 8'hB7);
    rb(1'h0, 8'h13);
    rb(1'h1, 8'hB6);
    stop_c();
    chk("burst restore", reg_ptr, 8'h12);
    burst_en <= 1'h0;
    // foreign address, then the address select moved to it
    start_c();
    wb(8'h8E, 1'h1);
    stop_c();
    addr_sel <= 2'h3;
    start_c();
    wb(8'h8E, 1'h0);
    wb(8'h21, 1'h0);
    stop_c();
    chk("pointer", reg_ptr, 8'h21);
    // high speed entry, repeated starts, exit on stop
    start_c();
    wb(8'h0B, 1'h1);
    chk("hs entered", hs_mode, 1'h1);
    hs <= 1'h1;
    start_c();
    wb(8'h8E, 1'h0);
    start_c();
    chk("hs kept", hs_mode, 1'h1);
    wb(8'h8F, 1'h0);
    rb(1'h1, 8'h21);
    hs <= 1'h0;
    stop_c();
    chk("hs left", hs_mode, 1'h0);
    // scl held low past the timeout
    start_c();
    wb(8'h08, 1'h1);
    chk("hs entered", hs_mode, 1'h1);
    repeat (300) @(posedge hclk);
    chk("timeout", hs_mode, 1'h0);
    stop_c();
    // general call reset
    start_c();
    wb(8'h00, 1'h0);
    wb(8'h06, 1'h0);
    stop_c();
    chk("gc pulse", gc_cnt, 1);
    chk("gc pointer", reg_ptr, 8'h00);
    start_c();
    wb(8'h00, 1'h0);
    wb(8'h07, 1'h1);
    stop_c();
    chk("gc other byte", gc_cnt, 1);
    // alert response: transparent ignored, latched answered
    int_req <= 1'h1;
    flag_h <= 1'h1;
    start_c();
    wb(8'h19, 1'h1);
    stop_c();
    chk("int kept", int_act, 1'h1);
    latched_mode <= 1'h1;
    start_c();
    wb(8'h19, 1'h0);
    rb(1'h1, 8'h8F);
    stop_c();
    chk("int released", int_act, 1'h0);
    int_req <= 1'h0;
    results();
  end
endmodule
`default_nettype wire

/* File: lsi2c_ctl.sv */
// controller end: ahb-lite driven byte level i2c controller
`timescale 1ns/1ps
`default_nettype none
`include "lsi2c_params.svh"
module lsi2c_ctl #(
  parameter int FS_QTR = `LSI2C_FS_QTR_CYC,
  parameter int HS_QTR = `LSI2C_HS_QTR_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  lsi2c_if.ctl bus
);
  generate
    if (FS_QTR < 1 || HS_QTR < 1 || FS_QTR > 255 || HS_QTR > 255) begin : g_bad_qtr
      $error("lsi2c_ctl: quarter counts must be 1 to 255");
    end
  endgenerate

  // ==========================================================
  // ahb-lite slave
  logic wr_pend_r;
  logic [7:0] wofs_r;
  logic go;
  logic busy_r;
  logic hs_r;
  logic nack_cfg_r;
  logic rx_nack_r;
  logic [7:0] shreg_r;
  lsi2c_pkg::lsi2c_cmd_t cmd_r;

  assign go = wr_pend_r && wofs_r == `LSI2C_CTRL_OFS && !busy_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wofs_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend_r <= hwrite;
        wofs_r <= haddr[7:0];
        hrdata <= 32'h00000000;
        if (!hwrite && haddr[7:0] == `LSI2C_STAT_OFS) begin
          hrdata[`LSI2C_STAT_BUSY_BIT] <= busy_r;
          hrdata[`LSI2C_STAT_NACK_BIT] <= rx_nack_r;
          hrdata[`LSI2C_STAT_HS_BIT] <= hs_r;
          hrdata[`LSI2C_STAT_BYTE_LSB +: 8] <= shreg_r;
        end
      end
    end
  end

  // ==========================================================
  // command capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r <= lsi2c_pkg::CMD_START;
      hs_r <= 1'b0;
      nack_cfg_r <= 1'b0;
    end else if (go) begin
      cmd_r <= lsi2c_pkg::lsi2c_cmd_t'(hwdata[`LSI2C_CTRL_CMD_LSB +: 2]);
      hs_r <= hwdata[`LSI2C_CTRL_HS_BIT];
      nack_cfg_r <= hwdata[`LSI2C_CTRL_NACK_BIT];
    end
  end

  // ==========================================================
  // bit engine, four quarter phases per bit
  lsi2c_pkg::lsi2c_cst_t cst_r;
  logic [7:0] qcnt_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic scl_r;
  logic sda_oe_r;
  logic tick;
  logic bitval;

  assign tick = qcnt_r == 8'h00;
  assign bitval = (bit_r == 4'h8) ? (cmd_r == lsi2c_pkg::CMD_WRITE || nack_cfg_r) :
                  (cmd_r == lsi2c_pkg::CMD_WRITE ? shreg_r[7] : 1'b1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cst_r <= lsi2c_pkg::C_IDLE;
      busy_r <= 1'b0;
      qcnt_r <= 8'h00;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      scl_r <= 1'b1;
      sda_oe_r <= 1'b0;
      shreg_r <= 8'h00;
      rx_nack_r <= 1'b0;
    end else if (cst_r == lsi2c_pkg::C_IDLE) begin
      if (go) begin
        busy_r <= 1'b1;
        qcnt_r <= 8'h00;
        ph_r <= 2'h0;
        bit_r <= 4'h0;
        shreg_r <= hwdata[`LSI2C_CTRL_BYTE_LSB +: 8];
        case (lsi2c_pkg::lsi2c_cmd_t'(hwdata[`LSI2C_CTRL_CMD_LSB +: 2]))
          lsi2c_pkg::CMD_START: cst_r <= lsi2c_pkg::C_START;
          lsi2c_pkg::CMD_STOP: cst_r <= lsi2c_pkg::C_STOP;
          default: cst_r <= lsi2c_pkg::C_BIT;
        endcase
      end
    end else if (!tick) begin
      qcnt_r <= qcnt_r - 8'h01;
    end else begin
      qcnt_r <= hs_r ? 8'(HS_QTR - 1) : 8'(FS_QTR - 1);
      ph_r <= ph_r + 2'h1;
      case (cst_r)
        lsi2c_pkg::C_START: begin
          case (ph_r)
            2'h0: begin
              sda_oe_r <= 1'b0;
            end
            2'h1: scl_r <= 1'b1;
            2'h2: sda_oe_r <= 1'b1;
            default: begin
              scl_r <= 1'b0;
              cst_r <= lsi2c_pkg::C_IDLE;
              busy_r <= 1'b0;
            end
          endcase
        end
        lsi2c_pkg::C_STOP: begin
          case (ph_r)
            2'h0: begin
              scl_r <= 1'b0;
              sda_oe_r <= 1'b1;
            end
            2'h1: scl_r <= 1'b1;
            2'h2: sda_oe_r <= 1'b0;
            default: begin
              cst_r <= lsi2c_pkg::C_IDLE;
              busy_r <= 1'b0;
            end
          endcase
        end
        default: begin
          case (ph_r)
            2'h0: begin
              scl_r <= 1'b0;
              sda_oe_r <= !bitval;
            end
            2'h1: scl_r <= 1'b1;
            2'h2: begin
              if (bit_r == 4'h8) begin
                rx_nack_r <= bus.sda;
              end else begin
                shreg_r <= {shreg_r[6:0], bus.sda};
              end
            end
            default: begin
              scl_r <= 1'b0;
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                cst_r <= lsi2c_pkg::C_IDLE;
                busy_r <= 1'b0;
              end
            end
          endcase
        end
      endcase
    end
  end

  assign bus.scl = scl_r;
  assign bus.ctl_sda_oe = sda_oe_r;
  assign bus.ctl_sda_o = 1'b0;
endmodule
`default_nettype wire

/* File: lsi2c_if.sv */
// two-wire bus joining the controller end and the target end
`timescale 1ns/1ps
`default_nettype none
interface lsi2c_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // open drain with pull-up: low whenever an enabled driver drives low
  assign sda = !((ctl_sda_oe && !ctl_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport ctl (output scl, output ctl_sda_o, output ctl_sda_oe, input sda);
  modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface
`default_nettype wire

/* File: lsi2c_params.svh */
// constants of the light sensor i2c target link and its controller
`ifndef LSI2C_PARAMS_SVH
`define LSI2C_PARAMS_SVH

`define LSI2C_CLK_PERIOD_NS 5
`define LSI2C_ADDR_HI 5'h11
`define LSI2C_GC_ADDR 7'h00
`define LSI2C_GC_RESET 8'h06
`define LSI2C_ARA_ADDR 7'h0C
`define LSI2C_HS_CODE 5'h01
`define LSI2C_PTR_RST 8'h00
`define LSI2C_TIMEOUT_NS 28000000
`define LSI2C_TIMEOUT_CYC ((`LSI2C_TIMEOUT_NS + `LSI2C_CLK_PERIOD_NS - 1) / `LSI2C_CLK_PERIOD_NS)
`define LSI2C_FS_PERIOD_NS 2500
`define LSI2C_HS_PERIOD_NS 385
`define LSI2C_FS_QTR_CYC ((`LSI2C_FS_PERIOD_NS + 4 * `LSI2C_CLK_PERIOD_NS - 1) / (4 * `LSI2C_CLK_PERIOD_NS))
`define LSI2C_HS_QTR_CYC ((`LSI2C_HS_PERIOD_NS + 4 * `LSI2C_CLK_PERIOD_NS - 1) / (4 * `LSI2C_CLK_PERIOD_NS))
`define LSI2C_CTRL_OFS 8'h00
`define LSI2C_STAT_OFS 8'h04
`define LSI2C_CTRL_CMD_LSB 0
`define LSI2C_CTRL_HS_BIT 2
`define LSI2C_CTRL_NACK_BIT 3
`define LSI2C_CTRL_BYTE_LSB 8
`define LSI2C_STAT_BUSY_BIT 0
`define LSI2C_STAT_NACK_BIT 1
`define LSI2C_STAT_HS_BIT 2
`define LSI2C_STAT_BYTE_LSB 8

`endif

/* File: lsi2c_pkg.sv */
// types shared by both ends of the light sensor i2c link
`default_nettype none
package lsi2c_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RXB, ST_RXACK, ST_TX, ST_TXACK, ST_IGN} lsi2c_dst_t;
  typedef enum logic [1:0] {M_WR, M_RD, M_GC, M_ALERT} lsi2c_mode_t;
  typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} lsi2c_cmd_t;
  typedef enum logic [1:0] {C_IDLE, C_START, C_BIT, C_STOP} lsi2c_cst_t;
endpackage
`default_nettype wire

/* File: lsi2c_target.sv */
// target end: i2c register access, high-speed entry, general call, alert response
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lsi2c_params.svh"
module lsi2c_target #(
  parameter int TIMEOUT_CYC = `LSI2C_TIMEOUT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  lsi2c_if.dev bus,
  input wire logic [1:0] addr_sel,
  input wire logic [15:0] reg_rdata,
  input wire logic burst_en,
  input wire logic latched_mode,
  input wire logic int_req,
  input wire logic flag_h,
  output logic [7:0] reg_ptr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic gc_reset,
  output logic int_act,
  output logic hs_mode
);
  localparam int TCW = $clog2(TIMEOUT_CYC + 1);

  generate
    if (TIMEOUT_CYC < 2) begin : g_bad_tmo
      $error("lsi2c_target: TIMEOUT_CYC must be at least 2");
    end
  endgenerate

  // ==========================================================
  // bus edge detection
  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= bus.scl;
      sda_q_r <= bus.sda;
    end
  end

  assign scl_rise = bus.scl && !scl_q_r;
  assign scl_fall = !bus.scl && scl_q_r;
  assign start_c = bus.scl && scl_q_r && sda_q_r && !bus.sda;
  assign stop_c = bus.scl && scl_q_r && !sda_q_r && bus.sda;

  // ==========================================================
  // state and declarations
  lsi2c_pkg::lsi2c_dst_t state_r;
  lsi2c_pkg::lsi2c_mode_t mode_r;
  lsi2c_pkg::lsi2c_mode_t dec_mode;
  logic [2:0] bitcnt_r;
  logic [7:0] shreg_r;
  logic [7:0] rxb;
  logic [7:0] ld_byte;
  logic [15:0] word_r;
  logic [1:0] widx_r;
  logic [1:0] asel_r;
  logic [6:0] my_addr;
  logic first_r;
  logic ack_r;
  logic lo_r;
  logic cont_r;
  logic sda_oe_r;
  logic dec_ack;
  logic dec_hs;
  logic abort;
  logic byte_done;
  logic alert_win;
  logic lo_acked;
  logic int_rel_r;
  logic [TCW-1:0] tmo_cnt_r;
  logic tmo_hit;

  assign my_addr = {`LSI2C_ADDR_HI, asel_r};
  assign rxb = {shreg_r[6:0], bus.sda};
  assign abort = tmo_hit || stop_c || start_c;
  assign byte_done = !abort && state_r == lsi2c_pkg::ST_RX && scl_rise && bitcnt_r == 3'h7;
  assign alert_win = !abort && state_r == lsi2c_pkg::ST_TX && mode_r == lsi2c_pkg::M_ALERT
                     && scl_fall && bitcnt_r == 3'h7;
  assign lo_acked = !abort && state_r == lsi2c_pkg::ST_TXACK && scl_rise && !bus.sda
                    && lo_r && mode_r == lsi2c_pkg::M_RD;
  // flags are only read here, never cleared
  assign ld_byte = (mode_r == lsi2c_pkg::M_ALERT) ? {my_addr, flag_h} :
                   (lo_r ? word_r[7:0] : reg_rdata[15:8]);

  // ==========================================================
  // received byte decode
  always_comb begin
    dec_ack = 1'b0;
    dec_hs = 1'b0;
    dec_mode = mode_r;
    if (first_r) begin
      if (rxb[7:3] == `LSI2C_HS_CODE) begin
        dec_hs = 1'b1;
      end else if (rxb[7:1] == my_addr) begin
        dec_ack = 1'b1;
        dec_mode = rxb[0] ? lsi2c_pkg::M_RD : lsi2c_pkg::M_WR;
      end else if (rxb[7:1] == `LSI2C_GC_ADDR && !rxb[0]) begin
        dec_ack = 1'b1;
        dec_mode = lsi2c_pkg::M_GC;
      end else if (rxb[7:1] == `LSI2C_ARA_ADDR && rxb[0] && latched_mode && int_act) begin
        dec_ack = 1'b1;
        dec_mode = lsi2c_pkg::M_ALERT;
      end
    end else if (mode_r == lsi2c_pkg::M_GC) begin
      dec_ack = (rxb == `LSI2C_GC_RESET);
    end else begin
      dec_ack = 1'b1;
    end
  end

  // ==========================================================
  // bit level machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= lsi2c_pkg::ST_IDLE;
      mode_r <= lsi2c_pkg::M_WR;
      bitcnt_r <= 3'h0;
      shreg_r <= 8'h00;
      word_r <= 16'h0000;
      widx_r <= 2'h0;
      first_r <= 1'b0;
      ack_r <= 1'b0;
      lo_r <= 1'b0;
      cont_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (tmo_hit || stop_c) begin
      state_r <= lsi2c_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (start_c) begin
      state_r <= lsi2c_pkg::ST_RX;
      bitcnt_r <= 3'h0;
      first_r <= 1'b1;
      lo_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        lsi2c_pkg::ST_RX: begin
          if (scl_rise) begin
            shreg_r <= rxb;
            bitcnt_r <= bitcnt_r + 3'h1;
            if (bitcnt_r == 3'h7) begin
              first_r <= 1'b0;
              ack_r <= dec_ack;
              mode_r <= dec_mode;
              state_r <= lsi2c_pkg::ST_RXB;
              if (first_r) begin
                widx_r <= 2'h0;
              end else if (widx_r != 2'h3) begin
                widx_r <= widx_r + 2'h1;
              end
            end
          end
        end
        lsi2c_pkg::ST_RXB: begin
          if (scl_fall) begin
            sda_oe_r <= ack_r;
            state_r <= ack_r ? lsi2c_pkg::ST_RXACK : lsi2c_pkg::ST_IGN;
          end
        end
        lsi2c_pkg::ST_RXACK: begin
          if (scl_fall) begin
            bitcnt_r <= 3'h0;
            if (mode_r == lsi2c_pkg::M_RD || mode_r == lsi2c_pkg::M_ALERT) begin
              state_r <= lsi2c_pkg::ST_TX;
              shreg_r <= ld_byte;
              sda_oe_r <= !ld_byte[7];
              if (!lo_r) begin
                word_r <= reg_rdata;
              end
            end else begin
              state_r <= lsi2c_pkg::ST_RX;
              sda_oe_r <= 1'b0;
            end
          end
        end
        lsi2c_pkg::ST_TX: begin
          if (scl_rise && mode_r == lsi2c_pkg::M_ALERT && !sda_oe_r && !bus.sda) begin
            state_r <= lsi2c_pkg::ST_IGN;
          end else if (scl_fall) begin
            if (bitcnt_r == 3'h7) begin
              sda_oe_r <= 1'b0;
              state_r <= lsi2c_pkg::ST_TXACK;
            end else begin
              shreg_r <= {shreg_r[6:0], 1'b0};
              sda_oe_r <= !shreg_r[6];
              bitcnt_r <= bitcnt_r + 3'h1;
            end
          end
        end
        lsi2c_pkg::ST_TXACK: begin
          if (scl_rise) begin
            cont_r <= !bus.sda && mode_r == lsi2c_pkg::M_RD;
            if (!bus.sda) begin
              lo_r <= !lo_r;
            end
          end else if (scl_fall) begin
            bitcnt_r <= 3'h0;
            if (cont_r) begin
              state_r <= lsi2c_pkg::ST_TX;
              shreg_r <= ld_byte;
              sda_oe_r <= !ld_byte[7];
              if (!lo_r) begin
                word_r <= reg_rdata;
              end
            end else begin
              state_r <= lsi2c_pkg::ST_IGN;
            end
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // address select capture, at every start including repeated starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asel_r <= 2'h0;
    end else if (start_c) begin
      asel_r <= addr_sel;
    end
  end

  // ==========================================================
  // register pointer, write data and general call
  logic [7:0] ptr_save_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_ptr <= `LSI2C_PTR_RST;
      ptr_save_r <= `LSI2C_PTR_RST;
      reg_wr <= 1'b0;
      reg_wdata <= 16'h0000;
      gc_reset <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      gc_reset <= 1'b0;
      if (byte_done && !first_r && mode_r == lsi2c_pkg::M_GC && dec_ack) begin
        gc_reset <= 1'b1;
        reg_ptr <= `LSI2C_PTR_RST;
        ptr_save_r <= `LSI2C_PTR_RST;
      end else if (byte_done && !first_r && mode_r == lsi2c_pkg::M_WR) begin
        if (widx_r == 2'h0) begin
          reg_ptr <= rxb;
          ptr_save_r <= rxb;
        end else if (widx_r == 2'h1) begin
          reg_wdata[15:8] <= rxb;
        end else if (widx_r == 2'h2) begin
          reg_wdata[7:0] <= rxb;
          reg_wr <= 1'b1;
        end
      end else if (lo_acked && burst_en) begin
        reg_ptr <= reg_ptr + 8'h01;
      end else if (stop_c && burst_en) begin
        reg_ptr <= ptr_save_r;
      end
    end
  end

  // ==========================================================
  // high-speed filter mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_mode <= 1'b0;
    end else if (stop_c || tmo_hit) begin
      hs_mode <= 1'b0;
    end else if (byte_done && first_r && dec_hs) begin
      hs_mode <= 1'b1;
    end
  end

  // ==========================================================
  // interrupt release by alert response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_rel_r <= 1'b0;
      int_act <= 1'b0;
    end else begin
      if (!int_req) begin
        int_rel_r <= 1'b0;
      end else if (alert_win) begin
        int_rel_r <= 1'b1;
      end
      int_act <= int_req && !int_rel_r && !alert_win;
    end
  end

  // ==========================================================
  // stuck clock timeout
  assign tmo_hit = !bus.scl && tmo_cnt_r == TCW'(TIMEOUT_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_cnt_r <= '0;
    end else if (bus.scl || state_r == lsi2c_pkg::ST_IDLE || tmo_hit) begin
      tmo_cnt_r <= '0;
    end else begin
      tmo_cnt_r <= tmo_cnt_r + TCW'(1);
    end
  end

  // ==========================================================
  // pin drive: open drain, only the enable moves
  assign bus.dev_sda_oe = sda_oe_r;
  assign bus.dev_sda_o = 1'b0;
endmodule
`default_nettype wire
